// ### design/cvx_map.svh
/*
 * Register offsets, reset values, field positions and bus-timing constants of the cell-voltage register block.
 * Assumes it is included once per compilation unit by its bare name; the guard below makes repeats harmless.
 */
`ifndef CVX_MAP_SVH
`define CVX_MAP_SVH

// Register indices on the two-wire link
`define CVX_REG_CELL_V      8'h09
`define CVX_REG_CELL_AVG    8'h19
`define CVX_REG_EXTREMES    8'h1b

// Power-up value of the extremes register: peak 0x00, floor 0xff
`define CVX_EXT_RESET       16'h00ff

// Extremes layout: peak in the upper byte, floor in the lower byte
`define CVX_EXT_PEAK_HI     15
`define CVX_EXT_PEAK_LO     8
`define CVX_EXT_FLOOR_HI    7
`define CVX_EXT_FLOOR_LO    0

// 20 mV extremes step is 256 voltage steps of 78.125 uV, so the field is the reading's upper byte
`define CVX_SRC_HI          15
`define CVX_SRC_LO          8

// Standard formats: voltage step in nanovolts, fraction bits of percent and temperature types
`define CVX_VOLT_LSB_NV     78125
// Percentage types: 8 fraction bits, so the upper byte alone reads whole percent
`define CVX_PCT_FRAC_BITS   8
// Temperature types: signed two's complement, 8 fraction bits; current types are signed too
`define CVX_TEMP_FRAC_BITS  8

// Bit counter marks of one byte on the link
`define CVX_CNT_ACK         4'h8
`define CVX_CNT_DONE        4'h9

`endif

// ### design/cvx_pkg.sv
/*
 * Types shared by the cell-voltage register block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cvx_pkg;

  // Link-side transfer phases
  typedef enum logic [1:0] {
    CVX_IDLE,
    CVX_ADDR,
    CVX_RX,
    CVX_TX
  } cvx_state_t;

  // One 16-bit fuel-gauge register word
  typedef logic [15:0] cvx_word_t;

endpackage : cvx_pkg

// ### design/cvx_sync.sv
/*
 * Two-flop synchroniser for a group of asynchronous pin levels.
 * Assumes each bit is a slow level; multi-bit groups are not coherent words.
 */
module cvx_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             sys_clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("cvx_sync needs WIDTH of at least one");
    end
  endgenerate

  logic [WIDTH-1:0] meta_ff;  // First stage, read only by the second

  // Two stages; pins idle high on the bus, so reset to ones
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= '1;
      q_out   <= '1;
    end else begin
      meta_ff <= d_in;
      q_out   <= meta_ff;
    end
  end

endmodule : cvx_sync

// ### design/cvx_gauge_regs.sv
/*
 * Cell-voltage registers with peak/floor tracking, read and written over a two-wire link slave.
 * Assumes a front end that pulses meas_valid with a new reading, and an external pull-up on the data wire.
 */
`include "cvx_map.svh"

module cvx_gauge_regs
  import cvx_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR  = 7'h36,  // Link address; plain default
  parameter int         AVG_SHIFT = 3       // Averaging weight is 1/2**AVG_SHIFT
) (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  input  wire logic        meas_valid,
  input  wire logic [15:0] meas_voltage,
  output logic             sda_o,
  output logic             sda_oe
);

  generate
    if (AVG_SHIFT < 1 || AVG_SHIFT > 8) begin : g_bad_shift
      $error("cvx_gauge_regs supports AVG_SHIFT from 1 to 8");
    end
  endgenerate

  logic [1:0]  pins_s;          // Synchronised {clock, data}
  logic        scl_q_ff;        // Previous clock level
  logic        sda_q_ff;        // Previous data level
  cvx_state_t  st_ff;           // Transfer phase
  logic [3:0]  cnt_ff;          // Clock rises within the byte
  logic [7:0]  shreg_ff;        // Received bits
  logic [7:0]  tx_ff;           // Bits still to send
  logic [7:0]  ptr_ff;          // Register pointer
  logic        ptr_loaded_ff;   // Pointer byte taken in this write
  logic        hi_ff;           // Low byte done, high byte next
  logic [7:0]  lo_hold_ff;      // Written low byte waits for its partner
  logic        ext_wr_ff;       // One-cycle write strobe to extremes
  cvx_word_t   ext_wdata_ff;    // Word written to extremes
  cvx_word_t   volt_ff;         // Instant reading
  cvx_word_t   avg_ff;          // Averaged reading
  logic        avg_seen_ff;     // A reading has arrived
  cvx_word_t   ext_ff;          // {peak, floor}
  logic        pristine_ff;     // No update or write since reset

  wire logic scl_s = pins_s[1];
  wire logic sda_s = pins_s[0];
  wire logic scl_rise = scl_s & ~scl_q_ff;
  wire logic scl_fall = ~scl_s & scl_q_ff;
  wire logic start_c  = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
  wire logic stop_c   = scl_s & scl_q_ff & ~sda_q_ff & sda_s;

  cvx_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .d_in    ({scl_i, sda_i}),
    .q_out   (pins_s)
  );

  // Edge history of the synchronised pins
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      scl_q_ff <= scl_s;
      sda_q_ff <= sda_s;
    end
  end

  // Read mux; next byte is picked from where the pointer will be
  logic [7:0] tx_ptr;
  logic       tx_hi;
  cvx_word_t  rd_word;
  logic [7:0] rd_byte;
  always_comb begin
    tx_ptr = (st_ff == CVX_TX && hi_ff) ? ptr_ff + 8'h01 : ptr_ff;
    tx_hi  = (st_ff == CVX_TX) ? ~hi_ff : 1'b0;
    if (tx_ptr == `CVX_REG_CELL_V) begin
      rd_word = volt_ff;
    end else if (tx_ptr == `CVX_REG_CELL_AVG) begin
      rd_word = avg_ff;
    end else if (tx_ptr == `CVX_REG_EXTREMES) begin
      rd_word = ext_ff;
    end else begin
      rd_word = 16'h0000;  // Unmapped indices read as zero
    end
    rd_byte = tx_hi ? rd_word[15:8] : rd_word[7:0];  // Low byte goes first
  end

  // Link slave: address, pointer, word writes and auto-incrementing reads
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff         <= CVX_IDLE;
      cnt_ff        <= 4'h0;
      shreg_ff      <= 8'h00;
      tx_ff         <= 8'h00;
      ptr_ff        <= 8'h00;
      ptr_loaded_ff <= 1'b0;
      hi_ff         <= 1'b0;
      lo_hold_ff    <= 8'h00;
      ext_wr_ff     <= 1'b0;
      ext_wdata_ff  <= 16'h0000;
      sda_oe        <= 1'b0;
    end else begin
      ext_wr_ff <= 1'b0;
      if (start_c) begin
        st_ff         <= CVX_ADDR;
        cnt_ff        <= 4'h0;
        hi_ff         <= 1'b0;
        ptr_loaded_ff <= 1'b0;  // Repeated start keeps the pointer itself
        sda_oe        <= 1'b0;
      end else if (stop_c) begin
        st_ff  <= CVX_IDLE;
        sda_oe <= 1'b0;
      end else if (scl_rise && st_ff != CVX_IDLE) begin
        if (cnt_ff < `CVX_CNT_ACK) begin
          shreg_ff <= {shreg_ff[6:0], sda_s};
          cnt_ff   <= cnt_ff + 4'h1;
        end else begin
          cnt_ff <= `CVX_CNT_DONE;
          if (st_ff == CVX_TX && sda_s) begin
            st_ff <= CVX_IDLE;  // Master refused more data
          end
        end
      end else if (scl_fall && st_ff != CVX_IDLE) begin
        case (st_ff)
          CVX_ADDR: begin
            if (cnt_ff == `CVX_CNT_ACK) begin
              if (shreg_ff[7:1] == DEV_ADDR) begin
                sda_oe <= 1'b1;  // Acknowledge our address
              end else begin
                st_ff <= CVX_IDLE;  // Not ours: stay off the wire
              end
            end else if (cnt_ff == `CVX_CNT_DONE) begin
              cnt_ff <= 4'h0;
              if (shreg_ff[0]) begin
                st_ff  <= CVX_TX;
                hi_ff  <= tx_hi;
                ptr_ff <= tx_ptr;
                tx_ff  <= {rd_byte[6:0], 1'b0};
                sda_oe <= ~rd_byte[7];
              end else begin
                st_ff  <= CVX_RX;
                sda_oe <= 1'b0;
              end
            end
          end
          CVX_RX: begin
            if (cnt_ff == `CVX_CNT_ACK) begin
              sda_oe <= 1'b1;
            end else if (cnt_ff == `CVX_CNT_DONE) begin
              sda_oe <= 1'b0;
              cnt_ff <= 4'h0;
              if (!ptr_loaded_ff) begin
                ptr_ff        <= shreg_ff;
                ptr_loaded_ff <= 1'b1;
              end else if (!hi_ff) begin
                lo_hold_ff <= shreg_ff;
                hi_ff      <= 1'b1;
              end else begin
                // Whole word in: only the extremes register takes it
                hi_ff  <= 1'b0;
                ptr_ff <= ptr_ff + 8'h01;
                if (ptr_ff == `CVX_REG_EXTREMES) begin
                  ext_wr_ff    <= 1'b1;
                  ext_wdata_ff <= {shreg_ff, lo_hold_ff};
                end
              end
            end
          end
          CVX_TX: begin
            if (cnt_ff == `CVX_CNT_ACK) begin
              sda_oe <= 1'b0;  // Let the master acknowledge
            end else if (cnt_ff == `CVX_CNT_DONE) begin
              cnt_ff <= 4'h0;
              hi_ff  <= tx_hi;
              ptr_ff <= tx_ptr;
              tx_ff  <= {rd_byte[6:0], 1'b0};
              sda_oe <= ~rd_byte[7];
            end else begin
              tx_ff  <= {tx_ff[6:0], 1'b0};
              sda_oe <= ~tx_ff[7];  // Open drain: pull low for a zero
            end
          end
          default: begin
            st_ff <= CVX_IDLE;
          end
        endcase
      end
    end
  end

  // Data line only ever pulls low
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  // Instant reading, stored unsigned as delivered
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      volt_ff <= 16'h0000;
    end else if (meas_valid) begin
      volt_ff <= meas_voltage;
    end
  end

  // Exponential average; the first reading seeds it so start-up is not dragged from zero
  logic signed [16:0] avg_diff;
  logic signed [16:0] avg_step;
  logic        [16:0] avg_sum;
  always_comb begin
    avg_diff = $signed({1'b0, meas_voltage}) - $signed({1'b0, avg_ff});
    avg_step = avg_diff >>> AVG_SHIFT;
    avg_sum  = 17'({1'b0, avg_ff}) + 17'(avg_step);
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      avg_ff      <= 16'h0000;
      avg_seen_ff <= 1'b0;
    end else if (meas_valid) begin
      avg_seen_ff <= 1'b1;
      if (!avg_seen_ff) begin
        avg_ff <= meas_voltage;
      end else begin
        avg_ff <= avg_sum[15:0];
      end
    end
  end

  // Extremes: a host write lands first, then a same-cycle reading is compared against it
  cvx_word_t  ext_base;
  logic [7:0] ext_src;
  cvx_word_t  nxt_ext;
  always_comb begin
    ext_base = ext_wr_ff ? ext_wdata_ff : ext_ff;
    ext_src  = meas_voltage[`CVX_SRC_HI:`CVX_SRC_LO];
    nxt_ext  = ext_base;
    if (meas_valid && ext_src > ext_base[`CVX_EXT_PEAK_HI:`CVX_EXT_PEAK_LO]) begin
      nxt_ext[`CVX_EXT_PEAK_HI:`CVX_EXT_PEAK_LO] = ext_src;
    end
    if (meas_valid && ext_src < ext_base[`CVX_EXT_FLOOR_HI:`CVX_EXT_FLOOR_LO]) begin
      nxt_ext[`CVX_EXT_FLOOR_HI:`CVX_EXT_FLOOR_LO] = ext_src;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_ff      <= `CVX_EXT_RESET;
      pristine_ff <= 1'b1;
    end else begin
      ext_ff      <= nxt_ext;
      pristine_ff <= pristine_ff & ~meas_valid & ~ext_wr_ff;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  chk_ext_power_up:  assert property (pristine_ff |-> ext_ff == `CVX_EXT_RESET)
    else $error("extremes left power-up value without cause");
  chk_volt_capture:  assert property (meas_valid |=> volt_ff == $past(meas_voltage))
    else $error("instant register missed a reading");
  chk_avg_seed:      assert property (meas_valid && !avg_seen_ff |=> avg_ff == $past(meas_voltage))
    else $error("average not seeded by first reading");
  chk_avg_hold:      assert property (!meas_valid |=> $stable(avg_ff))
    else $error("average moved without a reading");
  chk_peak_rise:     assert property (meas_valid && !ext_wr_ff |=>
      ext_ff[`CVX_EXT_PEAK_HI:`CVX_EXT_PEAK_LO] >= $past(meas_voltage[`CVX_SRC_HI:`CVX_SRC_LO])
      && ext_ff[`CVX_EXT_PEAK_HI:`CVX_EXT_PEAK_LO] >= $past(ext_ff[`CVX_EXT_PEAK_HI:`CVX_EXT_PEAK_LO]))
    else $error("peak field below a reading");
  chk_floor_fall:    assert property (meas_valid && !ext_wr_ff |=>
      ext_ff[`CVX_EXT_FLOOR_HI:`CVX_EXT_FLOOR_LO] <= $past(meas_voltage[`CVX_SRC_HI:`CVX_SRC_LO])
      && ext_ff[`CVX_EXT_FLOOR_HI:`CVX_EXT_FLOOR_LO] <= $past(ext_ff[`CVX_EXT_FLOOR_HI:`CVX_EXT_FLOOR_LO]))
    else $error("floor field above a reading");
  chk_first_update:  assert property (pristine_ff && meas_valid |=>
                                      ext_ff == {2{$past(meas_voltage[`CVX_SRC_HI:`CVX_SRC_LO])}})
    else $error("first update did not set both fields");
  chk_ext_restart:   assert property (ext_wr_ff && !meas_valid |=> ext_ff == $past(ext_wdata_ff))
    else $error("host write to extremes lost");
  chk_ext_quiet:     assert property (!meas_valid && !ext_wr_ff |=> $stable(ext_ff))
    else $error("extremes changed with no cause");
  chk_stop_release:  assert property (stop_c |=> !sda_oe ##1 st_ff == CVX_IDLE)
    else $error("data line held after stop");

endmodule : cvx_gauge_regs

// ### tb/cvx_host_model.sv
/*
 * Host processor model: masters the two-wire link that reaches the gauge registers.
 * Assumes the bench resolves the open-drain data wire with a pull-up and feeds it back.
 */
module cvx_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h36,  // Slave address that the host calls
  parameter int         HALF     = 10      // Clocks per link clock phase, above the 8 asked
) (
  input  wire logic sys_clk,
  input  wire logic sda_wire,
  output logic      scl_o,
  output logic      sda_rel
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle link: clock high, data released
  initial begin
    scl_o   = 1'b1;
    sda_rel = 1'b1;
  end

  // One link clock phase; callers always sit on a rising edge
  task automatic ph();
    repeat (HALF) @(posedge sys_clk);
  endtask : ph

  // Start or repeated start: data falls while the clock is high
  task automatic start();
    sda_rel <= 1'b1;
    ph();
    scl_o <= 1'b1;
    ph();
    sda_rel <= 1'b0;
    ph();
    scl_o <= 1'b0;
    ph();
  endtask : start

  // Stop: data rises while the clock is high, then the wire is left released
  task automatic stop();
    sda_rel <= 1'b0;
    ph();
    scl_o <= 1'b1;
    ph();
    sda_rel <= 1'b1;
    ph();
  endtask : stop

  // One bit clock; the wire is sampled on a falling edge, away from the slave's updates
  task automatic bit_x(input logic d, output logic q);
    sda_rel <= d;
    ph();
    scl_o <= 1'b1;
    repeat (HALF - 1) @(posedge sys_clk);
    @(negedge sys_clk) q = sda_wire;
    @(posedge sys_clk);
    scl_o <= 1'b0;
    ph();
  endtask : bit_x

  // Byte out, MSB first, then the ack clock with the wire released
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic q;
    for (int i = 7; i >= 0; i--) bit_x(d[i], q);
    bit_x(1'b1, q);
    ack = ~q;
  endtask : wr_byte

  // Byte in; last drives a NACK so the slave lets go of the wire
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic q;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(last, q);
  endtask : rd_byte

  // Word write, low byte first; reports whether the address was acked
  task automatic wr_word(input logic [6:0] a, input logic [7:0] ptr, input logic [15:0] w, output logic ack);
    logic k;
    start();
    wr_byte({a, 1'b0}, ack);
    wr_byte(ptr, k);
    wr_byte(w[7:0], k);
    wr_byte(w[15:8], k);
    stop();
  endtask : wr_word

  // Word read: pointer write, repeated start, two bytes, NACK on the second
  task automatic rd_word(input logic [7:0] ptr, output logic [15:0] w);
    logic k;
    start();
    wr_byte({DEV_ADDR, 1'b0}, k);
    wr_byte(ptr, k);
    start();
    wr_byte({DEV_ADDR, 1'b1}, k);
    rd_byte(1'b0, w[7:0]);
    rd_byte(1'b1, w[15:8]);
    stop();
  endtask : rd_word
endmodule : cvx_host_model

// ### tb/testbench.sv
/*
 * Self-checking bench for the cell-voltage registers, with a host model on the link.
 * Assumes the design package and register map header are compiled first.
 */
`include "cvx_map.svh"

module testbench
  import cvx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic      sys_clk = 1'b0;  // 100 MHz system clock
  logic      arst_n;          // Active-low reset
  logic      meas_valid;      // Reading strobe to the design
  cvx_word_t meas_voltage;    // Reading value
  logic      scl;             // Link clock from the host
  logic      sda_rel;         // Host data drive, 1 = released
  logic      sda_o;           // Slave data value
  logic      sda_oe;          // Slave pull-down enable
  wire logic sda_wire;        // Resolved wire with pull-up
  int        num_errors = 0;  // Mismatches seen
  int        cmp_count  = 0;  // Comparisons made
  cvx_word_t exp_avg;         // Bench copy of the averaged reading
  logic      seeded;          // First reading seeds the average

  // Pull-up wins unless a party pulls low
  assign sda_wire = (sda_oe ? sda_o : 1'b1) & sda_rel;

  // Clock generator
  always #5 sys_clk = ~sys_clk;

  cvx_gauge_regs #(.DEV_ADDR(7'h36), .AVG_SHIFT(3)) u_dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .scl_i(scl), .sda_i(sda_wire), .meas_valid(meas_valid),
    .meas_voltage(meas_voltage), .sda_o(sda_o), .sda_oe(sda_oe));

  cvx_host_model #(.DEV_ADDR(7'h36), .HALF(10)) u_host (
    .sys_clk(sys_clk), .sda_wire(sda_wire), .scl_o(scl), .sda_rel(sda_rel));

  // Report and end the run
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  // Compare one word; four-state so an unknown never matches
  task automatic chk(input string what, input cvx_word_t exp, input cvx_word_t got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Read a register over the link and compare it
  task automatic rd_chk(input string what, input logic [7:0] ptr, input cvx_word_t exp);
    cvx_word_t got;
    u_host.rd_word(ptr, got);
    chk(what, exp, got);
  endtask : rd_chk

  // Present one reading; last drops the strobe so pulses can run back to back
  task automatic meas(input cvx_word_t v, input logic last);
    logic signed [16:0] d;
    d = $signed({1'b0, v}) - $signed({1'b0, exp_avg});
    exp_avg = seeded ? exp_avg + cvx_word_t'(d >>> 3) : v;
    seeded = 1'b1;
    meas_valid <= 1'b1;
    meas_voltage <= v;
    @(posedge sys_clk);
    if (last) begin
      meas_valid <= 1'b0;
    end
  endtask : meas

  task automatic t_reset();
    rd_chk("extremes at reset", `CVX_REG_EXTREMES, 16'h00ff);
    rd_chk("instant at reset", `CVX_REG_CELL_V, 16'h0000);
  endtask : t_reset

  task automatic t_first();
    meas(16'h1234, 1'b1);
    rd_chk("instant", `CVX_REG_CELL_V, 16'h1234);
    rd_chk("average seed", `CVX_REG_CELL_AVG, exp_avg);
    rd_chk("extremes first", `CVX_REG_EXTREMES, 16'h1212);
  endtask : t_first

  // Back-to-back readings that raise the peak and lower the floor
  task automatic t_track();
    meas(16'h2000, 1'b0);
    meas(16'h0800, 1'b0);
    meas(16'h1f80, 1'b1);
    rd_chk("instant last", `CVX_REG_CELL_V, 16'h1f80);
    rd_chk("average", `CVX_REG_CELL_AVG, exp_avg);
    rd_chk("extremes tracked", `CVX_REG_EXTREMES, 16'h2008);
  endtask : t_track

  // Host restarts tracking, then one reading sets both fields
  task automatic t_clear();
    logic ack;
    u_host.wr_word(7'h36, `CVX_REG_EXTREMES, 16'h00ff, ack);
    chk("address ack", 16'h0001, {15'h0000, ack});
    rd_chk("extremes cleared", `CVX_REG_EXTREMES, 16'h00ff);
    meas(16'h1500, 1'b1);
    rd_chk("extremes after clear", `CVX_REG_EXTREMES, 16'h1515);
  endtask : t_clear

  // Read-only write, unmapped read and a foreign address
  task automatic t_access();
    logic ack;
    u_host.wr_word(7'h36, `CVX_REG_CELL_V, 16'habcd, ack);
    chk("read-only write ack", 16'h0001, {15'h0000, ack});
    rd_chk("instant read-only", `CVX_REG_CELL_V, 16'h1500);
    rd_chk("unmapped read", 8'h40, 16'h0000);
    u_host.wr_word(7'h37, `CVX_REG_EXTREMES, 16'h0000, ack);
    chk("foreign address ack", 16'h0000, {15'h0000, ack});
    rd_chk("extremes kept", `CVX_REG_EXTREMES, 16'h1515);
  endtask : t_access

  // Main sequence: reset for 20 cycles, let the pin sync settle, run scenarios
  initial begin
    arst_n       = 1'b0;
    meas_valid   = 1'b0;
    meas_voltage = 16'h0000;
    exp_avg      = 16'h0000;
    seeded       = 1'b0;
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_reset();
    t_first();
    t_track();
    t_clear();
    t_access();
    stop_test();
  end

  // Watchdog well beyond the expected run of about 22500 cycles
  initial begin
    repeat (80000) @(posedge sys_clk);
    num_errors++;
    stop_test();
  end
endmodule : testbench
